/* File: btc_pkg.sv */
// Package for the baseband test and matched-filter configuration register bank.
// Assumes byte-wide registers reached over a 32-bit Avalon-MM slave.
package btc_pkg;
  // Printed offsets (register indices); byte address is four times the index
  localparam logic [7:0] IDX_CS2_SCALE  = 8'h3C;
  localparam logic [7:0] IDX_TX_POWER   = 8'h3E;
  localparam logic [7:0] IDX_TEST_ONE   = 8'h40;
  localparam logic [7:0] IDX_TEST_TWO   = 8'h42;
  localparam logic [7:0] IDX_TBUS_SEL   = 8'h44;
  localparam logic [7:0] IDX_ED_THRESH  = 8'h46;
  localparam logic [7:0] IDX_DSPREAD    = 8'h48;
  localparam logic [7:0] IDX_CW_FORCE   = 8'h4A;
  localparam logic [7:0] IDX_SNR_ONE    = 8'h4C;
  localparam logic [7:0] IDX_SNR_TWO    = 8'h4E;
  localparam logic [7:0] IDX_STATUS     = 8'h70;
  localparam int         ADDR_W         = 10;
  // Reset values
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] RST_TEST_ONE   = 8'h20;
  // Field positions, first test register
  localparam int T1_DAC_SRC   = 7;
  localparam int T1_HIRATE    = 6;
  localparam int T1_LEN_EN    = 5;
  localparam int T1_TBUS_IN   = 4;
  localparam int T1_NO_SPREAD = 3;
  localparam int T1_NO_SCRAM  = 2;
  localparam int T1_PN44      = 1;
  localparam int T1_PN22      = 0;
  // Field positions, second test register
  localparam int T2_COH_AGC   = 7;
  localparam int T2_TT_FORCE  = 6;
  localparam int T2_NO_DC     = 5;
  localparam int T2_ADC_BYP   = 4;
  localparam int T2_TT_OFF    = 3;
  localparam int T2_LOOPBACK  = 2;
  localparam int T2_PN_LO     = 1;
  localparam int T2_PN_HI     = 0;
  localparam int CW_FORCE_DEF = 6;
  localparam int CW_FORCE_CAL = 5;
  localparam int ED_ABS       = 7;
  localparam int SVC_LOCK_BIT = 2;

  // Avalon request carrier
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
  } btc_req_s;

  // Datapath modes driven to the baseband core
  typedef struct packed {
    logic dac_iq_src;
    logic force_high_rate;
    logic length_count_en;
    logic no_spread;
    logic no_scramble;
    logic pn44_en;
    logic pn22_en;
    logic coh_agc_off;
    logic dc_comp_off;
    logic loopback;
    logic time_track_locked;
    logic time_track_off;
    logic use_default_weights;
  } btc_mode_s;
endpackage

/* File: btc_regs.sv */
// Configuration register bank: carrier sense, transmit power, test modes,
// energy detect and matched-filter weight selection.
// Assumes one 40 MHz clock; the power strobe and pin inputs are asynchronous.
//
// Summary of operation
// - Six low bits hold an unsigned 3.3 second carrier sense scale.
// - Transmit power is a seven-bit two's complement code; lowest bit reserved.
// - Power code reaches the DAC only on a power enable strobe rising edge.
// - First test bit 7 picks Barker or low-rate I/Q for DAC test 7.
// - First test bit 6 forces high-rate mode.
// - First test bit 5 enables the length field counter.
// - First test bit 4 tristates test bus and makes it an input.
// - Bit 3 removes spreading at low rates; bit 2 zeroes scrambler taps.
// - PN generator enables; software writes zero before one to initialise.
// - Second test bit 6: zero detects service lock bit, one forces lock.
// - Automatic lock needs service bit 2 and signalling config bit 2 set.
// - Second test bit 5 disables final DC offset compensation.
// - ADC bypass feeds test bus nibbles into I/Q bits 5:2, LSBs zero.
// - Second test bit 3 stops time tracking, overriding forced lock.
// - Loopback bypasses converters; serial data pin becomes acquisition lock.
// - Bits 1 and 0 route PN onto low and high test bus address bits.
// - Eight-bit test bus address selects the observed internal signal.
// - Energy detect asserts when signal strength exceeds the seven-bit threshold.
// - Energy detect top bit picks noise-floor relative or absolute threshold.
// - Default weights on weak signal per CW, SNR and spread tests, else calculated.
// - Spread count 7:5 evaluation only; spread threshold and CW threshold 4:0.
// - Force default and force calculated must never both be set; if both are, force default wins.
`timescale 1ns/10ps
module btc_regs
  import btc_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  input  wire logic                 CLK,
  input  wire logic                 RESETN,
  input  wire btc_pkg::btc_req_s    AVS_REQ,
  output logic      [31:0]          AVS_READDATA,
  output logic                      AVS_WAITREQUEST,
  input  wire logic                 TX_POWER_ENABLE_STROBE,
  output logic      [6:0]           TX_POWER_DAC,
  output logic      [5:0]           CS2_SCALE,
  output btc_pkg::btc_mode_s        MODE,
  input  wire logic [DATA_W-1:0]    TEST_BUS_INPUT,
  output logic      [DATA_W-1:0]    TEST_BUS_OUT,
  output logic      [DATA_W-1:0]    TEST_BUS_OE,
  input  wire logic [DATA_W-1:0]    TEST_SIGNALS,
  output logic      [7:0]           TEST_BUS_ADDR,
  input  wire logic [7:0]           PN_BITS,
  input  wire logic                 SERIAL_DATA_IN_PIN,
  output logic                      ACQ_LOCK,
  input  wire logic [5:0]           ADC_I,
  input  wire logic [5:0]           ADC_Q,
  output logic      [5:0]           I_SAMPLE,
  output logic      [5:0]           Q_SAMPLE,
  input  wire logic [7:0]           RSSI,
  input  wire logic [7:0]           NOISE_FLOOR,
  input  wire logic                 CW_PRESENT,
  input  wire logic [4:0]           DELAY_SPREAD,
  input  wire logic                 SERVICE_BIT2,
  input  wire logic [7:0]           TRANSMIT_SIGNALLING_CONFIG,
  output logic                      ENERGY_DETECT
);
  import btc_pkg::*;

  logic [7:0] cs2_reg, txp_reg, t1_reg, t2_reg, tbus_reg, ed_reg, ds_reg, cw_reg;
  logic [7:0] snr1_reg, snr2_reg;
  logic [7:0] word_idx;
  logic       hit_write, hit_read;
  logic [7:0] rd_byte;
  logic [2:0] transmit_power_enable_strobe_sync;
  logic [DATA_W-1:0] tin_s1, tin_s2;
  logic       sdi_s1, sdi_s2;
  logic [8:0] ed_ref, cw_lim, snr1_lim, snr2_lim;
  logic       want_default;

  // Word index from byte address; the low two address bits are ignored
  assign word_idx  = AVS_REQ.address[ADDR_W-1:2];
  assign hit_write = AVS_REQ.write && !AVS_WAITREQUEST;  // Lands at the accepting edge
  assign hit_read  = AVS_REQ.read && AVS_WAITREQUEST;    // Data captured in the wait cycle

  // One wait cycle, then accept; waitrequest returns high after the accepted edge
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= !((AVS_REQ.read || AVS_REQ.write) && AVS_WAITREQUEST);
  end

  // Register writes; reserved bits stored as written
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      cs2_reg  <= RST_BYTE;
      txp_reg  <= RST_BYTE;
      t1_reg   <= RST_TEST_ONE;
      t2_reg   <= RST_BYTE;
      tbus_reg <= RST_BYTE;
      ed_reg   <= RST_BYTE;
      ds_reg   <= RST_BYTE;
      cw_reg   <= RST_BYTE;
      snr1_reg <= RST_BYTE;
      snr2_reg <= RST_BYTE;
    end
    else if (hit_write)
    begin
      unique case (word_idx)
        IDX_CS2_SCALE: cs2_reg  <= AVS_REQ.writedata[7:0];
        IDX_TX_POWER:  txp_reg  <= AVS_REQ.writedata[7:0];
        IDX_TEST_ONE:  t1_reg   <= AVS_REQ.writedata[7:0];
        IDX_TEST_TWO:  t2_reg   <= AVS_REQ.writedata[7:0];
        IDX_TBUS_SEL:  tbus_reg <= AVS_REQ.writedata[7:0];
        IDX_ED_THRESH: ed_reg   <= AVS_REQ.writedata[7:0];
        IDX_DSPREAD:   ds_reg   <= AVS_REQ.writedata[7:0];
        IDX_CW_FORCE:  cw_reg   <= AVS_REQ.writedata[7:0];
        IDX_SNR_ONE:   snr1_reg <= AVS_REQ.writedata[7:0];
        IDX_SNR_TWO:   snr2_reg <= AVS_REQ.writedata[7:0];
        default:       ;
      endcase
    end
  end

  // Read mux; unmapped words read zero
  always_comb
  begin
    unique case (word_idx)
      IDX_CS2_SCALE: rd_byte = cs2_reg;
      IDX_TX_POWER:  rd_byte = txp_reg;
      IDX_TEST_ONE:  rd_byte = t1_reg;
      IDX_TEST_TWO:  rd_byte = t2_reg;
      IDX_TBUS_SEL:  rd_byte = tbus_reg;
      IDX_ED_THRESH: rd_byte = ed_reg;
      IDX_DSPREAD:   rd_byte = ds_reg;
      IDX_CW_FORCE:  rd_byte = cw_reg;
      IDX_SNR_ONE:   rd_byte = snr1_reg;
      IDX_SNR_TWO:   rd_byte = snr2_reg;
      IDX_STATUS:    rd_byte = {5'h00, want_default, ACQ_LOCK, ENERGY_DETECT};
      default:       rd_byte = 8'h00;
    endcase
  end

  // Read data registered alongside the acknowledge
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      AVS_READDATA <= 32'h0000_0000;
    else if (hit_read)
      AVS_READDATA <= {24'h00_0000, rd_byte};
  end

  // Power strobe synchroniser plus edge history
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      transmit_power_enable_strobe_sync <= 3'h0;
    else
      transmit_power_enable_strobe_sync <= {transmit_power_enable_strobe_sync[1:0], TX_POWER_ENABLE_STROBE};
  end

  // DAC holds old code until a strobe rising edge
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      TX_POWER_DAC <= 7'h00;
    else if (transmit_power_enable_strobe_sync[1] && !transmit_power_enable_strobe_sync[2])
      TX_POWER_DAC <= txp_reg[7:1];
  end

  // Pin synchronisers for test bus and serial data
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tin_s1 <= '0;
      tin_s2 <= '0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end
    else
    begin
      tin_s1 <= TEST_BUS_INPUT;
      tin_s2 <= tin_s1;
      sdi_s1 <= SERIAL_DATA_IN_PIN;
      sdi_s2 <= sdi_s1;
    end
  end

  // Threshold references, nine bits to avoid wrap
  assign ed_ref   = ed_reg[ED_ABS] ? {2'b00, ed_reg[6:0]}
                                   : {2'b00, ed_reg[6:0]} + {1'b0, NOISE_FLOOR};
  assign cw_lim   = {4'h0, cw_reg[4:0]} + {1'b0, NOISE_FLOOR};
  assign snr1_lim = {5'h00, snr1_reg[3:0]} + {1'b0, NOISE_FLOOR};
  assign snr2_lim = {4'h0, snr2_reg[4:0]} + {1'b0, NOISE_FLOOR};

  // Weight choice from signal conditions
  always_comb
  begin
    want_default = (CW_PRESENT && ({1'b0, RSSI} < cw_lim))
                || (!CW_PRESENT && ({1'b0, RSSI} < snr1_lim))
                || (!CW_PRESENT && (DELAY_SPREAD < ds_reg[4:0])
                    && ({1'b0, RSSI} < snr2_lim));
    if (cw_reg[CW_FORCE_DEF])
      want_default = 1'b1;
    else if (cw_reg[CW_FORCE_CAL])
      want_default = 1'b0;
  end

  // Energy detect and mode outputs
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ENERGY_DETECT <= 1'b0;
      CS2_SCALE     <= 6'h00;
      MODE          <= '0;
      TEST_BUS_ADDR <= 8'h00;
      ACQ_LOCK      <= 1'b0;
    end
    else
    begin
      ENERGY_DETECT <= {1'b0, RSSI} > ed_ref;
      CS2_SCALE     <= cs2_reg[5:0];
      MODE.dac_iq_src      <= t1_reg[T1_DAC_SRC];
      MODE.force_high_rate <= t1_reg[T1_HIRATE];
      MODE.length_count_en <= t1_reg[T1_LEN_EN];
      MODE.no_spread       <= t1_reg[T1_NO_SPREAD];
      MODE.no_scramble     <= t1_reg[T1_NO_SCRAM];
      MODE.pn44_en         <= t1_reg[T1_PN44];
      MODE.pn22_en         <= t1_reg[T1_PN22];
      MODE.coh_agc_off     <= t2_reg[T2_COH_AGC];
      MODE.dc_comp_off     <= t2_reg[T2_NO_DC];
      MODE.loopback        <= t2_reg[T2_LOOPBACK];
      MODE.time_track_off  <= t2_reg[T2_TT_OFF];
      MODE.time_track_locked <= !t2_reg[T2_TT_OFF]
        && (t2_reg[T2_TT_FORCE]
            || (SERVICE_BIT2 && TRANSMIT_SIGNALLING_CONFIG[SVC_LOCK_BIT]));
      MODE.use_default_weights <= want_default;
      // PN replaces low bits 2:0 and high bits 7:3 of the address
      TEST_BUS_ADDR <= {t2_reg[T2_PN_HI] ? PN_BITS[7:3] : tbus_reg[7:3],
                        t2_reg[T2_PN_LO] ? PN_BITS[2:0] : tbus_reg[2:0]};
      ACQ_LOCK      <= t2_reg[T2_LOOPBACK] && sdi_s2;
    end
  end

  // Test bus drive: output unless turned into an input
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      TEST_BUS_OUT <= '0;
      TEST_BUS_OE  <= '0;
    end
    else
    begin
      TEST_BUS_OUT <= TEST_SIGNALS;
      TEST_BUS_OE  <= {DATA_W{!t1_reg[T1_TBUS_IN]}};
    end
  end

  // Sample source: converters or test bus nibbles in bypass
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      I_SAMPLE <= 6'h00;
      Q_SAMPLE <= 6'h00;
    end
    else if (t2_reg[T2_ADC_BYP])
    begin
      I_SAMPLE <= {tin_s2[3:0], 2'b00};
      Q_SAMPLE <= {tin_s2[7:4], 2'b00};
    end
    else
    begin
      I_SAMPLE <= ADC_I;
      Q_SAMPLE <= ADC_Q;
    end
  end
endmodule

/* File: btc_regs_checker.sv */
// Checker for the register bank's bus handshake and mode outputs.
// Assumes it is bound to btc_regs and sees only its ports.
`timescale 1ns/10ps
module btc_regs_checker
  import btc_pkg::*;
(
  input wire logic               CLK,
  input wire logic               RESETN,
  input wire btc_pkg::btc_req_s  AVS_REQ,
  input wire logic [31:0]        AVS_READDATA,
  input wire logic               AVS_WAITREQUEST,
  input wire logic               TX_POWER_ENABLE_STROBE,
  input wire logic [6:0]         TX_POWER_DAC,
  input wire btc_pkg::btc_mode_s MODE,
  input wire logic               ACQ_LOCK,
  input wire logic               SERVICE_BIT2,
  input wire logic [7:0]         TRANSMIT_SIGNALLING_CONFIG
);
  // One clock domain for every property
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  // Bus answer, strobe hold, time tracking and acquisition lock
  property p_wait_resp;
    (AVS_REQ.read || AVS_REQ.write) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_wait_resp: assert property (p_wait_resp) else $error("access not answered in one cycle");
  property p_wait_one;
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_ack_req;
    !AVS_WAITREQUEST |-> $past(AVS_REQ.read || AVS_REQ.write);
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("answer without request");
  property p_rd_upper;
    !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
  property p_dac_hold;
    !TX_POWER_ENABLE_STROBE [*5] |=> $stable(TX_POWER_DAC);
  endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("power code moved without strobe");
  property p_track_prio;
    MODE.time_track_off |-> !MODE.time_track_locked;
  endproperty
  a_track_prio: assert property (p_track_prio) else $error("tracking off not dominant");
  property p_auto_lock;
    (SERVICE_BIT2 && TRANSMIT_SIGNALLING_CONFIG[2]) [*2]
      |=> MODE.time_track_locked || MODE.time_track_off;
  endproperty
  a_auto_lock: assert property (p_auto_lock) else $error("automatic lock missed");
  property p_acq;
    ACQ_LOCK |-> MODE.loopback || $past(MODE.loopback);
  endproperty
  a_acq: assert property (p_acq) else $error("lock input outside loopback");
  // Main scenarios reached
  c_write: cover property (AVS_REQ.write && !AVS_WAITREQUEST);
  c_strobe: cover property ($rose(TX_POWER_ENABLE_STROBE));
  c_locked: cover property (MODE.time_track_locked);
  c_default: cover property (MODE.use_default_weights);
endmodule

/* File: tb.sv */
// Self-checking bench for btc_regs: random register and pin traffic.
// Assumes the checker file is compiled before it.
`timescale 1ns/10ps
module tb;
  import btc_pkg::*;
  logic        clk, resetn, wq, stb, serial_data_in_pin, acq, cw, svc, ed, e_ed, e_def;
  logic [31:0] rdata;
  logic [7:0]  tbi, tsig, tbo, tboe, tba, pn, rssi, nf, tsc, q, rv [10];
  logic [6:0]  dac, pdac;
  logic [5:0]  cs2, adi, adq, is, qs;
  logic [4:0]  ds;
  btc_req_s    req;
  btc_mode_s   mode;
  int          err_total, comparisons;
  btc_regs dut (.CLK(clk), .RESETN(resetn), .AVS_REQ(req), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wq), .TX_POWER_ENABLE_STROBE(stb), .TX_POWER_DAC(dac),
    .CS2_SCALE(cs2), .MODE(mode), .TEST_BUS_INPUT(tbi), .TEST_BUS_OUT(tbo),
    .TEST_BUS_OE(tboe), .TEST_SIGNALS(tsig), .TEST_BUS_ADDR(tba), .PN_BITS(pn),
    .SERIAL_DATA_IN_PIN(serial_data_in_pin), .ACQ_LOCK(acq), .ADC_I(adi), .ADC_Q(adq), .I_SAMPLE(is),
    .Q_SAMPLE(qs), .RSSI(rssi), .NOISE_FLOOR(nf), .CW_PRESENT(cw), .DELAY_SPREAD(ds),
    .SERVICE_BIT2(svc), .TRANSMIT_SIGNALLING_CONFIG(tsc), .ENERGY_DETECT(ed));
  // Clock, 25 ns period
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("mismatches=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task xfer(input logic rd, input logic [7:0] ix, input logic [7:0] wd);
    req <= '{address: {ix, 2'b00}, read: rd, write: !rd, writedata: {24'h000000, wd}};
    @(posedge clk);
    while (wq !== 1'b0)
      @(posedge clk);
    q = rdata[7:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk);
  endtask
  // Weight selection formula on the weak signal tests
  function automatic logic f_def(input logic [7:0] r, input logic [7:0] f,
                                 input logic [4:0] ct, input logic [4:0] s1,
                                 input logic [4:0] s2, input logic [4:0] dt,
                                 input logic [4:0] d, input logic c);
    logic [8:0] a;
    a = {1'b0, r};
    return (c && a < f + ct) || (!c && a < f + s1) || (!c && d < dt && a < f + s2);
  endfunction
  // Watchdog
  initial
  begin
    #2000000;
    err_total++;
    print_verdict;
  end
  // Main sequence
  initial
  begin
    resetn = 1'b0; req = '0; stb = 1'b0; serial_data_in_pin = 1'b0; cw = 1'b0; svc = 1'b0; tbi = 8'h00;
    tsig = 8'h00; pn = 8'h00; rssi = 8'h00; nf = 8'h00; tsc = 8'h00; adi = 6'h00;
    adq = 6'h00; ds = 5'h00; pdac = 7'h00;
    void'($urandom(32'hBD34CA4C));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    check(mode.length_count_en, 1'b1);
    for (int i = 0; i < 11; i++)
    begin
      xfer(1'b1, (i < 10) ? IDX_CS2_SCALE + 8'(2 * i) : 8'h20, 8'h00);
      check(q, (i == 2) ? RST_TEST_ONE : RST_BYTE);
    end
    for (int it = 0; it < 40; it++)
    begin
      foreach (rv[i]) rv[i] = 8'($urandom);
      rv[7][5] = rv[7][6] ? 1'b0 : rv[7][5];
      rv[0][7:6] = 2'b00;
      rv[1][0] = 1'b0;
      rv[7][7] = 1'b0;
      rv[8][7:4] = 4'h0;
      rv[9][7:5] = 3'h0;
      {serial_data_in_pin, cw, svc, tbi, tsig, pn, rssi, nf, tsc} <= 51'({$urandom, $urandom});
      {adi, adq, ds} <= 17'($urandom);
      xfer(1'b0, IDX_TEST_ONE, rv[2] & 8'hFC);
      if (it % 4 == 0)
        rssi <= nf + {4'h0, rv[8][3:0]};
      for (int i = 0; i < 10; i++) xfer(1'b0, IDX_CS2_SCALE + 8'(2 * i), rv[i]);
      for (int i = 0; i < 10; i++)
      begin
        xfer(1'b1, IDX_CS2_SCALE + 8'(2 * i), 8'h00);
        check(q, rv[i]);
      end
      xfer(1'b0, 8'h21, 8'h5A);
      xfer(1'b1, 8'h21, 8'h00);
      check(q, 8'h00);
      repeat (5) @(posedge clk);
      check(cs2, rv[0][5:0]);
      check({mode.dac_iq_src, mode.force_high_rate, mode.length_count_en}, rv[2][7:5]);
      check({mode.no_spread, mode.no_scramble, mode.pn44_en, mode.pn22_en}, rv[2][3:0]);
      check({mode.coh_agc_off, mode.dc_comp_off, mode.loopback}, {rv[3][7], rv[3][5], rv[3][2]});
      check({mode.time_track_off, mode.time_track_locked},
            {rv[3][3], !rv[3][3] && (rv[3][6] || (svc && tsc[2]))});
      check(tboe, rv[2][4] ? 8'h00 : 8'hFF);
      check({is, qs}, rv[3][4] ? {tbi[3:0], 2'b00, tbi[7:4], 2'b00} : {adi, adq});
      check(acq, rv[3][2] && serial_data_in_pin);
      check(tba, {rv[3][0] ? pn[7:3] : rv[4][7:3], rv[3][1] ? pn[2:0] : rv[4][2:0]});
      e_ed = {1'b0, rssi} > {2'b00, rv[5][6:0]} + (rv[5][7] ? 9'h000 : {1'b0, nf});
      e_def = rv[7][6] || (!rv[7][5] && f_def(rssi, nf, rv[7][4:0],
              {1'b0, rv[8][3:0]}, rv[9][4:0], rv[6][4:0], ds, cw));
      check(ed, e_ed);
      check(mode.use_default_weights, e_def);
      check(tbo, tsig);
      xfer(1'b1, IDX_STATUS, 8'h00);
      check(q, {5'h00, e_def, rv[3][2] && serial_data_in_pin, e_ed});
      check(dac, pdac);
      stb <= 1'b1;
      repeat (3) @(posedge clk);
      stb <= 1'b0;
      repeat (6) @(posedge clk);
      pdac = rv[1][7:1];
      check(dac, pdac);
    end
    print_verdict;
  end
endmodule
bind btc_regs btc_regs_checker u_chk (.CLK(CLK), .RESETN(RESETN), .AVS_REQ(AVS_REQ),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .TX_POWER_ENABLE_STROBE(TX_POWER_ENABLE_STROBE), .TX_POWER_DAC(TX_POWER_DAC),
  .MODE(MODE), .ACQ_LOCK(ACQ_LOCK), .SERVICE_BIT2(SERVICE_BIT2),
  .TRANSMIT_SIGNALLING_CONFIG(TRANSMIT_SIGNALLING_CONFIG));
